/* File: hdl/sir_isp_top.sv */
// Serial programming record interpreter with autobaud and security byte
// Notes on behaviour
// - Characters are 8 data bits, no parity, two stop bits, no flow control.
// - Host sends U; device times its start bit for the bit rate.
// - After reset nothing is interpreted until bit-rate training completes.
// - Each record starts with a colon, the frame delimiter.
// - Fields: length, two-byte offset, type, data, checksum.
// - Every byte travels as two ASCII hex digits.
// - Load offset is the start address only for data programming records.
// - Record type selects the command and the data meaning.
// - Bytes from length through checksum sum to zero modulo 256.
// - Every received character is echoed before the response.
// - Checksum mismatch discards the command and answers X CR LF.
// - Security FFh, FEh, FCh; programming may only move stricter.
// - Write-protect level refuses flash, boot status and vector writes with P.
// - Read-write-protect level refuses flash and EEPROM access with L.
// - Level 1 read-only, no block erase; level 2 reads only security byte.
// - Info and blank check readable below level 2; full erase always allowed.
// - Only full chip erase or a reset restores the unprotected security value.
// - Full erase sets flash FFh, boot status FFh, vector FCh, security FFh.
// - Successful records answer with period, CR, LF.
// - Program record carries at most 128 bytes within one page.
// - Full chip erase lasts about six seconds before answering.
`timescale 1ns/10ps
module sir_isp_top import sir_pkg::*; #(
  parameter int unsigned ERASE_CYCLES = ERASE_CYC_DEF
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic rxd,
  output logic txd,
  output logic baud_ok,
  output logic mem_wr,
  output logic mem_sel,
  output logic [15:0] mem_addr,
  output logic [7:0] mem_data,
  output logic chip_erase,
  output logic ctl_wr,
  output logic [23:0] ctl_args,
  output logic [7:0] security_level_byte,
  output logic [7:0] boot_status_byte,
  output logic [7:0] software_boot_vector
);
  typedef enum logic [3:0] {
    ST_BAUD_LOW, ST_BAUD_MEAS, ST_BAUD_SETTLE, ST_IDLE, ST_HEX,
    ST_CHECK, ST_WRITE, ST_ERASE, ST_RESP
  } sir_state_t;

  localparam logic [25:0] ERASE_LAST = 26'(ERASE_CYCLES - 1);

  logic rst_meta, rst_n, rx_meta, rx_s;
  logic [7:0] rx_byte;
  logic rx_valid, tx_busy;
  sir_state_t state, next_state;
  logic [15:0] bit_cycles, next_bit_cycles;
  logic [25:0] cnt, next_cnt;
  logic nib, next_nib;
  logic [3:0] hi_nib, next_hi_nib;
  logic [8:0] bidx, next_bidx;
  logic [7:0] sum, next_sum, len, next_len, rtype, next_rtype;
  logic [15:0] addr, next_addr;
  logic [7:0] d0, next_d0, d1, next_d1, d2, next_d2;
  logic [7:0] resp_code, next_resp_code;
  logic [1:0] ridx, next_ridx;
  logic [7:0] widx, next_widx;
  logic tx_go, next_tx_go;
  logic [7:0] tx_byte, next_tx_byte;
  logic next_baud_ok, next_mem_wr, next_mem_sel, next_chip_erase, next_ctl_wr;
  logic [15:0] next_mem_addr;
  logic [7:0] next_mem_data, next_ssb, next_bsb, next_sbv;
  logic [23:0] next_ctl_args;
  logic buf_we;
  logic [4:0] hv;
  logic [7:0] nb;
  logic lvl1, lvl2;
  logic [7:0] dbuf [0:127];

  // Reset release through two stages; assertion stays asynchronous
  always_ff @(posedge mclk or negedge rstn) begin
    if (!rstn) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // Receive pin synchroniser; idle line is high
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rx_meta <= 1'b1;
      rx_s <= 1'b1;
    end else begin
      rx_meta <= rxd;
      rx_s <= rx_meta;
    end
  end

  sir_uart_rx sir_uart_rx_inst (
    .mclk(mclk),
    .rst_n(rst_n),
    .enable(baud_ok),
    .rxd(rx_s),
    .bit_cycles(bit_cycles),
    .rx_byte(rx_byte),
    .rx_valid(rx_valid)
  );

  sir_uart_tx sir_uart_tx_inst (
    .mclk(mclk),
    .rst_n(rst_n),
    .tx_go(tx_go),
    .tx_byte(tx_byte),
    .bit_cycles(bit_cycles),
    .txd(txd),
    .tx_busy(tx_busy)
  );

  // Hex digit to nibble, bit 4 flags a valid digit
  function automatic logic [4:0] hexval(input logic [7:0] c);
    if (c >= 8'h30 && c <= 8'h39) return {1'b1, c[3:0]};
    else if ((c >= 8'h41 && c <= 8'h46) || (c >= 8'h61 && c <= 8'h66))
      return {1'b1, 4'(c[3:0] + 4'h9)};
    else return 5'h00;
  endfunction : hexval

  assign hv = hexval(rx_byte);
  assign nb = {hi_nib, hv[3:0]};
  // Lock bits: bit 0 clear is write protect, bit 1 clear read-write protect
  assign lvl2 = !security_level_byte[1];
  assign lvl1 = !security_level_byte[0];

  // Main sequencer: training, parsing, checking and answering
  always_comb begin
    next_state = state;
    next_bit_cycles = bit_cycles;
    next_cnt = cnt;
    next_nib = nib;
    next_hi_nib = hi_nib;
    next_bidx = bidx;
    next_sum = sum;
    next_len = len;
    next_addr = addr;
    next_rtype = rtype;
    next_d0 = d0;
    next_d1 = d1;
    next_d2 = d2;
    next_resp_code = resp_code;
    next_ridx = ridx;
    next_widx = widx;
    next_tx_go = 1'b0;
    next_tx_byte = tx_byte;
    next_baud_ok = baud_ok;
    next_mem_wr = 1'b0;
    next_mem_sel = mem_sel;
    next_mem_addr = mem_addr;
    next_mem_data = mem_data;
    next_chip_erase = chip_erase;
    next_ctl_wr = 1'b0;
    next_ctl_args = ctl_args;
    next_ssb = security_level_byte;
    next_bsb = boot_status_byte;
    next_sbv = software_boot_vector;
    buf_we = 1'b0;
    // Echo each character as it lands
    if (rx_valid && baud_ok) begin
      next_tx_go = 1'b1;
      next_tx_byte = rx_byte;
    end
    case (state)
      // Start bit of U is one bit time
      ST_BAUD_LOW: if (!rx_s) begin
        next_state = ST_BAUD_MEAS;
        next_cnt = 26'h0000001;
      end
      ST_BAUD_MEAS: if (rx_s) begin
        next_bit_cycles = cnt[15:0];
        next_cnt = '0;
        next_state = (cnt[15:0] < MIN_BIT_CYC) ? ST_BAUD_LOW : ST_BAUD_SETTLE;
      end else if (cnt[15:0] != 16'hffff) next_cnt = cnt + 26'h0000001;
      // Let the rest of U pass before listening
      ST_BAUD_SETTLE: if (!rx_s) next_cnt = '0;
      else if (cnt == {9'h000, bit_cycles, 1'b0}) begin
        next_state = ST_IDLE;
        next_baud_ok = 1'b1;
      end else next_cnt = cnt + 26'h0000001;
      ST_IDLE, ST_HEX: if (rx_valid) begin
        // Colon always opens a fresh frame
        if (rx_byte == CH_COLON) begin
          next_state = ST_HEX;
          next_nib = 1'b0;
          next_bidx = '0;
          next_sum = 8'h00;
        end else if (state == ST_HEX) begin
          if (!hv[4]) next_state = ST_IDLE;
          else if (!nib) begin
            next_hi_nib = hv[3:0];
            next_nib = 1'b1;
          end else begin
            next_nib = 1'b0;
            next_sum = sum + nb;
            next_bidx = bidx + 9'h001;
            if (bidx == 9'h000) next_len = nb;
            if (bidx == 9'h001) next_addr[15:8] = nb;
            if (bidx == 9'h002) next_addr[7:0] = nb;
            if (bidx == 9'h003) next_rtype = nb;
            if (bidx == 9'h004) next_d0 = nb;
            if (bidx == 9'h005) next_d1 = nb;
            if (bidx == 9'h006) next_d2 = nb;
            buf_we = (bidx >= HDR_BYTES) && (bidx < HDR_BYTES + MAX_DATA);
            if (bidx >= HDR_BYTES && bidx == {1'b0, len} + HDR_BYTES)
              next_state = ST_CHECK;
          end
        end
      end
      ST_CHECK: begin
        next_state = ST_RESP;
        next_ridx = 2'h0;
        next_resp_code = CH_DOT;
        // Whole record must sum to zero
        if (sum != 8'h00 || {1'b0, len} > MAX_DATA) begin
          next_resp_code = CH_X;
        end else begin
          case (rtype)
            REC_PROG, REC_EEPROM: begin
              // Read-write protect wins over write protect
              if (lvl2) next_resp_code = CH_L;
              else if (lvl1) next_resp_code = CH_P;
              else if (len != 8'h00) begin
                next_state = ST_WRITE;
                next_widx = 8'h00;
                next_mem_sel = (rtype == REC_EEPROM);
              end
            end
            REC_WRITE: begin
              // AND of codes can only tighten the level
              if (d0 == WF_SEC) begin
                next_ssb = security_level_byte & ((d1 == 8'h00) ? SSB_WP : SSB_RDWR);
              // Full erase allowed at every level
              end else if (d0 == WF_ERASE) begin
                next_state = ST_ERASE;
                next_cnt = '0;
                next_chip_erase = 1'b1;
              // Boot bytes, fuses and block erase are locked
              end else if (lvl2) next_resp_code = CH_L;
              else if (lvl1) next_resp_code = CH_P;
              else if (d0 == WF_BOOT) begin
                if (d1 == 8'h00) next_bsb = d2;
                else next_sbv = d2;
              end else if (d0 == WF_CLR_BOOT) begin
                next_bsb = BSB_RST;
                next_sbv = BSB_RST;
              end else begin
                next_ctl_wr = 1'b1;
                next_ctl_args = {d0, d1, d2};
              end
            end
            // At level 2 only the security byte reads back
            REC_DISP, REC_READ: if (lvl2 &&
                !(rtype == REC_READ && d0 == RF_SEC && d1 == 8'h00))
              next_resp_code = CH_L;
            default: next_resp_code = CH_DOT;
          endcase
        end
      end
      // Offset used as address only here
      ST_WRITE: begin
        next_mem_wr = 1'b1;
        next_mem_addr = addr + {8'h00, widx};
        next_mem_data = dbuf[widx[6:0]];
        next_widx = widx + 8'h01;
        if (widx == len - 8'h01) next_state = ST_RESP;
      end
      // Erase holds for the full erase time
      ST_ERASE: if (cnt == ERASE_LAST) begin
        // Defaults restored; only path to unprotected apart from reset
        next_chip_erase = 1'b0;
        next_ssb = SSB_NONE;
        next_bsb = BSB_RST;
        next_sbv = SBV_RST;
        next_state = ST_RESP;
      end else next_cnt = cnt + 26'h0000001;
      // Response code then CR LF, after the echo drains
      default: if (!tx_busy && !tx_go && !rx_valid) begin
        next_tx_go = 1'b1;
        next_tx_byte = (ridx == 2'h0) ? resp_code : ((ridx == 2'h1) ? CH_CR : CH_LF);
        next_ridx = ridx + 2'h1;
        if (ridx == 2'h2) next_state = ST_IDLE;
      end
    endcase
  end

  // Data buffer holds a record until its checksum is proven
  always_ff @(posedge mclk) begin
    if (buf_we) dbuf[7'(bidx - HDR_BYTES)] <= nb;
  end

  // Sequencer registers
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_BAUD_LOW;
      bit_cycles <= 16'hffff;
      cnt <= '0;
      nib <= 1'b0;
      hi_nib <= 4'h0;
      bidx <= '0;
      sum <= 8'h00;
      len <= 8'h00;
      addr <= 16'h0000;
      rtype <= 8'h00;
      d0 <= 8'h00;
      d1 <= 8'h00;
      d2 <= 8'h00;
      resp_code <= CH_DOT;
      ridx <= 2'h0;
      widx <= 8'h00;
      tx_go <= 1'b0;
      tx_byte <= 8'h00;
      baud_ok <= 1'b0;
      mem_wr <= 1'b0;
      mem_sel <= 1'b0;
      mem_addr <= 16'h0000;
      mem_data <= 8'h00;
      chip_erase <= 1'b0;
      ctl_wr <= 1'b0;
      ctl_args <= 24'h000000;
      security_level_byte <= SSB_NONE;
      boot_status_byte <= BSB_RST;
      software_boot_vector <= SBV_RST;
    end else begin
      state <= next_state;
      bit_cycles <= next_bit_cycles;
      cnt <= next_cnt;
      nib <= next_nib;
      hi_nib <= next_hi_nib;
      bidx <= next_bidx;
      sum <= next_sum;
      len <= next_len;
      addr <= next_addr;
      rtype <= next_rtype;
      d0 <= next_d0;
      d1 <= next_d1;
      d2 <= next_d2;
      resp_code <= next_resp_code;
      ridx <= next_ridx;
      widx <= next_widx;
      tx_go <= next_tx_go;
      tx_byte <= next_tx_byte;
      baud_ok <= next_baud_ok;
      mem_wr <= next_mem_wr;
      mem_sel <= next_mem_sel;
      mem_addr <= next_mem_addr;
      mem_data <= next_mem_data;
      chip_erase <= next_chip_erase;
      ctl_wr <= next_ctl_wr;
      ctl_args <= next_ctl_args;
      security_level_byte <= next_ssb;
      boot_status_byte <= next_bsb;
      software_boot_vector <= next_sbv;
    end
  end

  // Checks on the sequencer
  property p_echo;
    @(posedge mclk) disable iff (!rst_n)
    rx_valid && baud_ok |=> tx_go && tx_byte == $past(rx_byte);
  endproperty
  a_echo: assert property (p_echo) else $error("echo missing");
  property p_train;
    @(posedge mclk) disable iff (!rst_n)
    !baud_ok |-> !tx_go && !mem_wr && state inside {ST_BAUD_LOW, ST_BAUD_MEAS, ST_BAUD_SETTLE};
  endproperty
  a_train: assert property (p_train) else $error("active before training");
  property p_csum;
    @(posedge mclk) disable iff (!rst_n)
    state == ST_CHECK && sum != 8'h00 |=> state == ST_RESP && resp_code == CH_X && !mem_wr;
  endproperty
  a_csum: assert property (p_csum) else $error("bad checksum not flagged");
  property p_wprot;
    @(posedge mclk) disable iff (!rst_n)
    mem_wr |-> security_level_byte == SSB_NONE;
  endproperty
  a_wprot: assert property (p_wprot) else $error("write under protection");
  property p_lock;
    @(posedge mclk) disable iff (!rst_n)
    state == ST_CHECK && sum == 8'h00 && {1'b0, len} <= MAX_DATA && lvl2 &&
      rtype == REC_PROG |=> resp_code == CH_L;
  endproperty
  a_lock: assert property (p_lock) else $error("level 2 access not refused");
  property p_stricter;
    @(posedge mclk) disable iff (!rst_n)
    $changed(security_level_byte) && security_level_byte != SSB_NONE |->
      (security_level_byte & $past(security_level_byte)) == security_level_byte;
  endproperty
  a_stricter: assert property (p_stricter) else $error("security loosened");
  property p_unlock;
    @(posedge mclk) disable iff (!rst_n)
    $changed(security_level_byte) && security_level_byte == SSB_NONE |->
      $past(state) == ST_ERASE;
  endproperty
  a_unlock: assert property (p_unlock) else $error("unlock without erase");
  property p_erase_vals;
    @(posedge mclk) disable iff (!rst_n)
    $fell(chip_erase) |-> security_level_byte == SSB_NONE &&
      boot_status_byte == BSB_RST && software_boot_vector == SBV_RST;
  endproperty
  a_erase_vals: assert property (p_erase_vals) else $error("erase defaults wrong");
  sequence s_erase_start;
    $rose(chip_erase);
  endsequence
  property p_erase_hold;
    @(posedge mclk) disable iff (!rst_n)
    s_erase_start |-> chip_erase[*8];
  endproperty
  a_erase_hold: assert property (p_erase_hold) else $error("erase too short");
  property p_tail;
    @(posedge mclk) disable iff (!rst_n)
    tx_go && $past(state) == ST_RESP && !$past(rx_valid) |-> tx_byte ==
      (($past(ridx) == 2'h0) ? $past(resp_code) : (($past(ridx) == 2'h1) ? CH_CR : CH_LF));
  endproperty
  a_tail: assert property (p_tail) else $error("response bytes wrong");
endmodule : sir_isp_top

/* File: hdl/sir_pkg.sv */
// Shared constants for the serial record interpreter
package sir_pkg;
  // Clock and timing
  localparam int unsigned CLK_KHZ = 10000;
  localparam int unsigned ERASE_TIME_MS = 6000;
  localparam int unsigned ERASE_CYC_DEF = ERASE_TIME_MS * CLK_KHZ;
  localparam logic [15:0] MIN_BIT_CYC = 16'h0004;
  // Record limits
  localparam logic [8:0] MAX_DATA = 9'h080;
  localparam logic [8:0] HDR_BYTES = 9'h004;
  // Characters
  localparam logic [7:0] CH_COLON = 8'h3a;
  localparam logic [7:0] CH_DOT = 8'h2e;
  localparam logic [7:0] CH_CR = 8'h0d;
  localparam logic [7:0] CH_LF = 8'h0a;
  localparam logic [7:0] CH_X = 8'h58;
  localparam logic [7:0] CH_P = 8'h50;
  localparam logic [7:0] CH_L = 8'h4c;
  // Record types
  localparam logic [7:0] REC_PROG = 8'h00;
  localparam logic [7:0] REC_WRITE = 8'h03;
  localparam logic [7:0] REC_DISP = 8'h04;
  localparam logic [7:0] REC_READ = 8'h05;
  localparam logic [7:0] REC_EEPROM = 8'h07;
  // Write and read function selectors (first data byte)
  localparam logic [7:0] WF_CLR_BOOT = 8'h04;
  localparam logic [7:0] WF_SEC = 8'h05;
  localparam logic [7:0] WF_BOOT = 8'h06;
  localparam logic [7:0] WF_ERASE = 8'h07;
  localparam logic [7:0] RF_SEC = 8'h07;
  // Security levels and reset values
  localparam logic [7:0] SSB_NONE = 8'hff;
  localparam logic [7:0] SSB_WP = 8'hfe;
  localparam logic [7:0] SSB_RDWR = 8'hfc;
  localparam logic [7:0] BSB_RST = 8'hff;
  localparam logic [7:0] SBV_RST = 8'hfc;
  // Serial framing: start, eight data, two stop
  localparam logic [3:0] TX_BITS_LAST = 4'ha;
  localparam logic [2:0] RX_BITS_LAST = 3'h7;
endpackage : sir_pkg

/* File: hdl/sir_uart_rx.sv */
// Receiver for 8 data bits, no parity, sampled mid-bit
`timescale 1ns/10ps
module sir_uart_rx import sir_pkg::*; (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic enable,
  input wire logic rxd,
  input wire logic [15:0] bit_cycles,
  output logic [7:0] rx_byte,
  output logic rx_valid
);
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_BITS, RX_STOP} sir_rx_state_t;
  sir_rx_state_t state, next_state;
  logic [15:0] cnt, next_cnt;
  logic [2:0] bitn, next_bitn;
  logic [7:0] shreg, next_shreg, next_rx_byte;
  logic next_rx_valid;

  // Bit sampling sequence; a bad stop bit drops the character
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_bitn = bitn;
    next_shreg = shreg;
    next_rx_byte = rx_byte;
    next_rx_valid = 1'b0;
    case (state)
      RX_IDLE: if (enable && !rxd) begin
        next_state = RX_START;
        next_cnt = {1'b0, bit_cycles[15:1]};
      end
      RX_START: if (cnt == 16'h0000) begin
        next_state = rxd ? RX_IDLE : RX_BITS;
        next_cnt = bit_cycles - 16'h0001;
        next_bitn = 3'h0;
      end else next_cnt = cnt - 16'h0001;
      RX_BITS: if (cnt == 16'h0000) begin
        next_shreg = {rxd, shreg[7:1]};
        next_cnt = bit_cycles - 16'h0001;
        next_bitn = bitn + 3'h1;
        if (bitn == RX_BITS_LAST) next_state = RX_STOP;
      end else next_cnt = cnt - 16'h0001;
      default: if (cnt == 16'h0000) begin
        next_state = RX_IDLE;
        next_rx_valid = rxd;
        if (rxd) next_rx_byte = shreg;
      end else next_cnt = cnt - 16'h0001;
    endcase
  end

  // Receiver state registers
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state <= RX_IDLE;
      cnt <= 16'h0000;
      bitn <= 3'h0;
      shreg <= 8'h00;
      rx_byte <= 8'h00;
      rx_valid <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      bitn <= next_bitn;
      shreg <= next_shreg;
      rx_byte <= next_rx_byte;
      rx_valid <= next_rx_valid;
    end
  end
endmodule : sir_uart_rx

/* File: hdl/sir_uart_tx.sv */
// Transmitter for 8 data bits, no parity, two stop bits
`timescale 1ns/10ps
module sir_uart_tx import sir_pkg::*; (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic tx_go,
  input wire logic [7:0] tx_byte,
  input wire logic [15:0] bit_cycles,
  output logic txd,
  output logic tx_busy
);
  typedef enum logic {TX_IDLE, TX_SHIFT} sir_tx_state_t;
  sir_tx_state_t state, next_state;
  logic [10:0] sh, next_sh;
  logic [15:0] cnt, next_cnt;
  logic [3:0] nbits, next_nbits;
  logic next_txd;

  assign tx_busy = (state == TX_SHIFT);

  // Frame of 11 bit times; line rests high after the second stop bit
  always_comb begin
    next_state = state;
    next_sh = sh;
    next_cnt = cnt;
    next_nbits = nbits;
    next_txd = txd;
    case (state)
      TX_IDLE: if (tx_go) begin
        next_state = TX_SHIFT;
        next_txd = 1'b0;
        next_sh = {1'b1, 2'b11, tx_byte};
        next_nbits = TX_BITS_LAST;
        next_cnt = bit_cycles - 16'h0001;
      end
      default: if (cnt != 16'h0000) begin
        next_cnt = cnt - 16'h0001;
      end else if (nbits == 4'h0) begin // Chain frames so echoes keep pace with the host
        next_state = tx_go ? TX_SHIFT : TX_IDLE;
        next_txd = !tx_go;
        next_sh = {1'b1, 2'b11, tx_byte};
        next_nbits = TX_BITS_LAST;
        next_cnt = bit_cycles - 16'h0001;
      end else begin
        next_txd = sh[0];
        next_sh = {1'b1, sh[10:1]};
        next_nbits = nbits - 4'h1;
        next_cnt = bit_cycles - 16'h0001;
      end
    endcase
  end

  // Transmitter state registers
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state <= TX_IDLE;
      sh <= 11'h7ff;
      cnt <= 16'h0000;
      nbits <= 4'h0;
      txd <= 1'b1;
    end else begin
      state <= next_state;
      sh <= next_sh;
      cnt <= next_cnt;
      nbits <= next_nbits;
      txd <= next_txd;
    end
  end
endmodule : sir_uart_tx

/* File: verification/sir_host_model.sv */
// Host programmer model: 8N2 serial sender and echo receiver
`timescale 1ns/10ps
module sir_host_model #(
  parameter int BIT = 16
) (
  input wire logic mclk,
  input wire logic txd,
  output logic rxd
);
  logic [7:0] got[$];
  // Idle line stays high between characters
  initial rxd = 1'b1;
  // Start, 8 data LSB first, 2 stop
  task automatic send(input logic [7:0] c);
    logic [10:0] f;
    f = {2'b11, c, 1'b0};
    for (int i = 0; i < 11; i++) begin
      rxd = f[i];
      repeat (BIT) @(negedge mclk);
    end
  endtask : send
  always begin : rx_loop
    logic [7:0] c;
    @(negedge txd);
    repeat (BIT / 2) @(posedge mclk);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT) @(posedge mclk);
      c[i] = txd;
    end
    repeat (BIT) @(posedge mclk); // Into first stop bit
    got.push_back(c);
  end
endmodule : sir_host_model

/* File: verification/sir_isp_top_tb_top.sv */
// Self-checking bench for the serial record interpreter
`timescale 1ns/10ps
`define CHK(n, e, s) begin samples_checked++; if ((s) !== (e)) begin err_total++; $display("ERROR %s exp %h got %h", n, e, s); end end
module sir_isp_top_tb_top;
  import sir_pkg::*;
  localparam int ER = 50;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic rxd, txd, baud_ok, mem_wr, mem_sel, chip_erase, ctl_wr;
  logic [15:0] mem_addr;
  logic [7:0] mem_data, security_level_byte, boot_status_byte, software_boot_vector;
  logic [23:0] ctl_args;
  int err_total = 0;
  int samples_checked = 0;
  int er_cyc = 0;
  int ctl_n = 0;
  logic [15:0] wa[$];
  logic [7:0] wd[$];
  // 10 MHz clock
  always #50 mclk = ~mclk;
  sir_isp_top #(.ERASE_CYCLES(ER)) sir_isp_top_inst (.mclk, .rstn, .rxd, .txd, .baud_ok,
    .mem_wr, .mem_sel, .mem_addr, .mem_data, .chip_erase, .ctl_wr, .ctl_args,
    .security_level_byte, .boot_status_byte, .software_boot_vector);
  sir_host_model #(.BIT(16)) sir_host_model_inst (.mclk, .txd, .rxd);
  // Log strobes and erase length mid-cycle, where outputs are settled
  always @(negedge mclk) begin
    if (mem_wr === 1'b1) begin
      wa.push_back(mem_addr);
      wd.push_back(mem_data);
    end
    if (chip_erase === 1'b1) er_cyc++;
    if (ctl_wr === 1'b1) ctl_n++;
  end
  function automatic logic [7:0] hx(input logic [3:0] n);
    return (n < 4'ha) ? 8'h30 + n : 8'h37 + n;
  endfunction : hx
  // Build frame, check echo and reply
  task automatic rec(input logic [7:0] b[$], input logic bad, input logic [7:0] code);
    logic [7:0] s;
    logic [7:0] f[$];
    int t;
    s = 8'h00;
    f = {CH_COLON};
    foreach (b[i]) begin
      s = s + b[i];
      f.push_back(hx(b[i][7:4]));
      f.push_back(hx(b[i][3:0]));
    end
    s = bad ? 8'h01 - s : 8'h00 - s; // Off by one when corrupted
    f.push_back(hx(s[7:4]));
    f.push_back(hx(s[3:0]));
    sir_host_model_inst.got.delete();
    foreach (f[i]) sir_host_model_inst.send(f[i]);
    t = 0;
    while (sir_host_model_inst.got.size() < f.size() + 3 && t < 20000) begin
      @(negedge mclk);
      t++;
    end
    foreach (f[i]) `CHK("echo", f[i], sir_host_model_inst.got[i])
    `CHK("code", code, sir_host_model_inst.got[f.size()])
    `CHK("cr", CH_CR, sir_host_model_inst.got[f.size() + 1])
    `CHK("lf", CH_LF, sir_host_model_inst.got[f.size() + 2])
  endtask : rec
  task automatic final_report();
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : final_report
  // Watchdog well beyond the expected run length
  initial begin
    repeat (95000) @(posedge mclk);
    err_total++;
    final_report();
  end
  initial begin
    repeat (8) @(negedge mclk);
    rstn = 1'b1;
    `CHK("sec0", SSB_NONE, security_level_byte)
    `CHK("boot0", BSB_RST, boot_status_byte)
    `CHK("vec0", SBV_RST, software_boot_vector)
    repeat (4) @(negedge mclk);
    `CHK("untrained", 1'b0, baud_ok)
    sir_host_model_inst.send(8'h55);
    for (int i = 0; i < 3000 && baud_ok !== 1'b1; i++) @(negedge mclk);
    `CHK("trained", 1'b1, baud_ok)
    rec('{8'h02, 8'h00, 8'h10, REC_PROG, 8'h55, 8'haa}, 1'b0, CH_DOT);
    `CHK("wa0", 16'h0010, wa[0])
    `CHK("wa1", 16'h0011, wa[1])
    `CHK("wd1", 8'haa, wd[1])
    `CHK("sel0", 1'b0, mem_sel)
    rec('{8'h01, 8'h00, 8'h20, REC_PROG, 8'h11}, 1'b1, CH_X);
    `CHK("discard", 2, wa.size())
    rec('{8'h03, 8'h00, 8'h00, REC_WRITE, WF_BOOT, 8'h00, 8'h55}, 1'b0, CH_DOT);
    `CHK("boot", 8'h55, boot_status_byte)
    rec('{8'h02, 8'h00, 8'h00, REC_WRITE, WF_CLR_BOOT, 8'h00}, 1'b0, CH_DOT);
    `CHK("boot_clr", 8'hff, boot_status_byte)
    `CHK("vec_clr", 8'hff, software_boot_vector)
    rec('{8'h02, 8'h00, 8'h00, REC_WRITE, WF_SEC, 8'h00}, 1'b0, CH_DOT);
    `CHK("sec1", SSB_WP, security_level_byte)
    rec('{8'h01, 8'h00, 8'h30, REC_PROG, 8'h11}, 1'b0, CH_P);
    rec('{8'h03, 8'h00, 8'h00, REC_WRITE, WF_BOOT, 8'h01, 8'h12}, 1'b0, CH_P);
    rec('{8'h03, 8'h00, 8'h00, REC_WRITE, 8'h01, 8'h20, 8'h00}, 1'b0, CH_P);
    rec('{8'h02, 8'h00, 8'h00, REC_WRITE, WF_SEC, 8'h01}, 1'b0, CH_DOT);
    `CHK("sec2", SSB_RDWR, security_level_byte)
    rec('{8'h02, 8'h00, 8'h00, REC_WRITE, WF_SEC, 8'h00}, 1'b0, CH_DOT);
    `CHK("nolower", SSB_RDWR, security_level_byte)
    rec('{8'h02, 8'h00, 8'h00, REC_READ, RF_SEC, 8'h00}, 1'b0, CH_DOT);
    rec('{8'h02, 8'h00, 8'h00, REC_READ, RF_SEC, 8'h01}, 1'b0, CH_L);
    rec('{8'h01, 8'h00, 8'h00, REC_DISP, 8'h00}, 1'b0, CH_L);
    rec('{8'h01, 8'h00, 8'h30, REC_PROG, 8'h11}, 1'b0, CH_L);
    rec('{8'h01, 8'h00, 8'h30, REC_EEPROM, 8'h11}, 1'b0, CH_L);
    `CHK("blocked", 2, wa.size())
    rec('{8'h01, 8'h00, 8'h00, REC_WRITE, WF_ERASE}, 1'b0, CH_DOT);
    `CHK("erlen", ER, er_cyc)
    `CHK("sec_er", SSB_NONE, security_level_byte)
    `CHK("boot_er", BSB_RST, boot_status_byte)
    `CHK("vec_er", SBV_RST, software_boot_vector)
    rec('{8'h01, 8'h00, 8'h40, REC_EEPROM, 8'h77}, 1'b0, CH_DOT);
    `CHK("sel1", 1'b1, mem_sel)
    `CHK("wa2", 16'h0040, wa[2])
    `CHK("wd2", 8'h77, wd[2])
    rec('{8'h03, 8'h00, 8'h00, REC_WRITE, 8'h01, 8'h20, 8'h00}, 1'b0, CH_DOT);
    `CHK("ctl_n", 1, ctl_n)
    `CHK("ctl_args", 24'h012000, ctl_args)
    final_report();
  end
endmodule : sir_isp_top_tb_top
